// ===== hw/rstc_map.vh
// Constants for the reset source controller: register indices,
// field codes, reset values and timing counts.
// Assumes a 20 MHz system clock on mclk_in.
`ifndef RSTC_MAP_VH
`define RSTC_MAP_VH

// Timing
`define RSTC_CLK_NS          50
`define RSTC_RELEASE_NS      50000000
`define RSTC_RELEASE_CYC     ((`RSTC_RELEASE_NS + `RSTC_CLK_NS - 1) / `RSTC_CLK_NS)
`define RSTC_BOR_MIN_NS      1000
`define RSTC_BOR_MIN_CYC     ((`RSTC_BOR_MIN_NS + `RSTC_CLK_NS - 1) / `RSTC_CLK_NS)
`define RSTC_WAKE_CYC        16
`define RSTC_FAULT_EDGES     3

// Register indices on the register port
`define RSTC_IDX_PIN_SEL     4'h0
`define RSTC_IDX_WDT_CTRL    4'h1
`define RSTC_IDX_WDT_PER     4'h2
`define RSTC_IDX_STATUS      4'h3
`define RSTC_IDX_INTERRUPT_CTRL0       4'h4
`define RSTC_IDX_TIMER0_CTRL       4'h5
`define RSTC_IDX_PA_DATA     4'h6
`define RSTC_IDX_PA_DIR      4'h7
`define RSTC_IDX_PA_PU       4'h8
`define RSTC_IDX_PA_WU       4'h9
`define RSTC_IDX_MP0         4'ha
`define RSTC_IDX_MP1         4'hb

// Field codes
`define RSTC_PIN_CODE_IO     5'h00
`define RSTC_PIN_CODE_RST    5'h15
`define RSTC_WDT_CODE_ON     6'h00
`define RSTC_WDT_CODE_OFF    6'h2d

// Status flag positions
`define RSTC_TO_BIT          5
`define RSTC_PDF_BIT         4

// Reset values
`define RSTC_RST_PIN_SEL     5'h00
`define RSTC_RST_WDT_CTRL    8'h00
`define RSTC_RST_WDT_PER     3'h7
`define RSTC_RST_INTERRUPT_CTRL0       8'h00
`define RSTC_RST_TIMER0_CTRL       8'h08
`define RSTC_RST_PA_DATA     8'hff
`define RSTC_RST_PA_DIR      8'hff
`define RSTC_RST_PA_PU       8'h00
`define RSTC_RST_PA_WU       8'h00
`define RSTC_RST_MP          8'h80
`define RSTC_MP_TOP_BIT      7

`endif

// ===== hw/rstc_sync.v
// Two-stage synchroniser for the release of the power-on reset.
// Assumes nrst_in is asynchronous; output asserts on mclk_in.
`timescale 1ns/10ps
`default_nettype none
module rstc_sync (
  input  wire mclk_in,
  input  wire nrst_in,
  output wire ready_out
);
  reg [1:0] sync_q;

  // Only the second stage is read
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_q <= 2'b00;
    end else begin
      sync_q <= {sync_q[0], 1'b1};
    end
  end

  assign ready_out = sync_q[1];
endmodule // rstc_sync
`default_nettype wire

// ===== hw/rstc_count.v
// Saturating persistence counter: done once inc_in has been seen LIMIT
// times without an intervening clear. Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
module rstc_count #(
  parameter         W     = 8,
  parameter [W-1:0] LIMIT = 8'd3
) (
  input  wire mclk_in,
  input  wire nrst_in,
  input  wire clr_in,
  input  wire inc_in,
  output wire done_out
);
  reg [W-1:0] cnt_q;

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= {W{1'b0}};
    end else if (clr_in) begin
      cnt_q <= {W{1'b0}};
    end else if (inc_in && cnt_q != LIMIT) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done_out = (cnt_q == LIMIT);
endmodule // rstc_count
`default_nettype wire

// ===== hw/rstc_ctrl.v
// Reset source controller: merges power-on, pin, brownout, code-fault
// and watchdog resets, keeps the flags and holds the reset registers.
// Assumes inputs other than nrst_in synchronous to mclk_in; slow RC level is sampled.
//
// Summary of operation
// - Pin reset while running zeroes program counter; fetch restarts there after release.
// - Pin select code 00000 plain I/O, 10101 reset input, others reset.
// - Invalid pin select code causes reset within 2 to 3 slow RC cycles.
// - Brownout on while awake; resets only when low supply outlasts minimum time.
// - Brownout detection disabled while the device sleeps.
// - Normal-mode watchdog expiry acts as pin reset and sets expiry flag.
// - Sleep-mode watchdog expiry clears PC, stack and watchdog, sets pointer bit 7 and expiry flag.
// - Sleep watchdog wake waits 16 system clocks when fast RC clocks.
// - Power-on clears both flags; brownout and pin reset while running keep; watchdog sets per mode.
// - Cold reset zeroes PC, disables interrupts, restarts watchdog, stops timer, inputs.
// - Cold resets set port data/direction ones, clear pullup, wake, pin select.
// - Cold resets load period 111, timer control 08, clear interrupt, watchdog.
// - Every reset sets pointer bit 7; PC low byte always cleared.
// - Pin reset while halted clears expiry, sets powerdown; timer count untouched.
// - Core held inactive an extra release delay after source goes away.
// - Watchdog code 101101 disables, 000000 enables, others cause reset.
`timescale 1ns/10ps
`default_nettype none
`include "rstc_map.vh"
module rstc_ctrl #(
  parameter RELEASE_CYC = `RSTC_RELEASE_CYC,
  parameter DW          = 20
) (
  input  wire       mclk_in,
  input  wire       nrst_in,
  input  wire       external_rst_n_in,
  input  wire       brownout_low_in,
  input  wire       slow_rc_osc_in,
  input  wire       fast_rc_sel_in,
  input  wire       sleep_in,
  input  wire       wdt_timeout_in,
  input  wire       reg_wr_in,
  input  wire [3:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  output reg  [7:0] reg_rdata_out,
  output wire       core_reset_out,
  output wire       pc_clear_out,
  output wire       sp_reset_out,
  output wire       warm_reset_out,
  output wire       wdt_clear_out,
  output wire       timer_prescaler_clr_out,
  output wire       pin_is_io_out,
  output wire       pin_is_reset_out,
  output wire       wdt_enabled_out,
  output wire       watchdog_expiry_flag_out,
  output wire       powerdown_flag_out,
  output wire [7:0] watchdog_control_out,
  output wire [2:0] watchdog_period_sel_out,
  output wire [7:0] interrupt_ctrl0_out,
  output wire [7:0] timer0_ctrl_out,
  output wire [7:0] port_a_data_out,
  output wire [7:0] port_a_direction_out,
  output wire [7:0] port_a_pullup_out,
  output wire [7:0] port_a_wake_enable_out,
  output wire [7:0] mem_pointer0_out,
  output wire [7:0] mem_pointer1_out
);
  localparam [1:0] ST_RUN   = 2'd0;
  localparam [1:0] ST_HOLD  = 2'd1;
  localparam [1:0] ST_DELAY = 2'd2;
  localparam [1:0] ST_WARM  = 2'd3;

  localparam [2:0] CA_POR   = 3'd0;
  localparam [2:0] CA_PIN   = 3'd1;
  localparam [2:0] CA_BOR   = 3'd2;
  localparam [2:0] CA_WDT   = 3'd3;
  localparam [2:0] CA_CODE  = 3'd4;

  localparam integer  REL_I     = RELEASE_CYC - 1;
  localparam integer  WAKE_I    = `RSTC_WAKE_CYC - 1;
  localparam integer  BOR_I     = `RSTC_BOR_MIN_CYC;
  localparam integer  FLT_I     = `RSTC_FAULT_EDGES;
  localparam [DW-1:0] REL_LAST  = REL_I[DW-1:0];
  localparam [4:0]    WAKE_LAST = WAKE_I[4:0];

  reg  [1:0]    state_q;
  reg  [2:0]    cause_q;
  reg  [DW-1:0] dly_q;
  reg  [4:0]    wake_q;
  reg           slow_q;
  reg           to_q;
  reg           pdf_q;
  reg  [4:0]    pin_sel_q;
  reg  [7:0]    wdt_ctrl_q;
  reg  [2:0]    wdt_per_q;
  reg  [7:0]    intc_q;
  reg  [7:0]    tmr_ctrl_q;
  reg  [7:0]    pa_data_q;
  reg  [7:0]    pa_dir_q;
  reg  [7:0]    pa_pu_q;
  reg  [7:0]    pa_wu_q;
  reg  [7:0]    mp0_q;
  reg  [7:0]    mp1_q;
  reg           pulse_q;

  wire          por_ready;
  wire          bor_fire;
  wire          fault_fire;
  wire          pin_mode_rst;
  wire          pin_code_bad;
  wire          wdt_code_bad;
  wire          code_bad;
  wire          pin_fire;
  wire          slow_rise;
  wire          wdt_cold;
  wire          wdt_warm;
  wire          cold_src;
  wire          in_reset;
  wire          cold_load;

  // Deassertion of the power-on reset nrst_in is synchronised to the system clock
  rstc_sync u_sync (
    .mclk_in   (mclk_in),
    .nrst_in   (nrst_in),
    .ready_out (por_ready)
  );

  // Supply must stay low for the whole minimum time; sleep disarms it
  rstc_count #(
    .W     (8),
    .LIMIT (BOR_I[7:0])
  ) u_bor (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .clr_in   (!brownout_low_in || sleep_in),
    .inc_in   (brownout_low_in),
    .done_out (bor_fire)
  );

  // Counting slow RC edges bounds the delay to 2..3 slow periods
  rstc_count #(
    .W     (2),
    .LIMIT (FLT_I[1:0])
  ) u_fault (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .clr_in   (!code_bad),
    .inc_in   (slow_rise),
    .done_out (fault_fire)
  );

  assign pin_mode_rst = (pin_sel_q == `RSTC_PIN_CODE_RST);
  assign pin_code_bad = !pin_mode_rst && (pin_sel_q != `RSTC_PIN_CODE_IO);
  assign wdt_code_bad = (wdt_ctrl_q[5:0] != `RSTC_WDT_CODE_ON) &&
                        (wdt_ctrl_q[5:0] != `RSTC_WDT_CODE_OFF);
  assign code_bad     = pin_code_bad || wdt_code_bad;
  assign slow_rise    = slow_rc_osc_in && !slow_q;
  assign pin_fire     = pin_mode_rst && !external_rst_n_in;
  assign wdt_cold     = wdt_timeout_in && !sleep_in;
  assign wdt_warm     = wdt_timeout_in && sleep_in;
  assign cold_src     = pin_fire || bor_fire || fault_fire || wdt_cold;
  assign in_reset     = (state_q != ST_RUN);
  assign cold_load    = (state_q == ST_HOLD);

  // Reset sequencer
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_HOLD;
      cause_q <= CA_POR;
      dly_q   <= {DW{1'b0}};
      wake_q  <= 5'd0;
      slow_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      slow_q  <= slow_rc_osc_in;
      pulse_q <= 1'b0;
      if (cold_src && state_q != ST_HOLD) begin
        state_q <= ST_HOLD;
        pulse_q <= 1'b1;
        if (pin_fire) begin
          cause_q <= CA_PIN;
        end else if (wdt_cold) begin
          cause_q <= CA_WDT;
        end else if (bor_fire) begin
          cause_q <= CA_BOR;
        end else begin
          cause_q <= CA_CODE;
        end
      end else begin
        case (state_q)
          ST_RUN: begin
            if (wdt_warm) begin
              state_q <= ST_WARM;
              wake_q  <= 5'd0;
              pulse_q <= 1'b1;
            end
          end
          ST_HOLD: begin
            // Pin cause waits for the pin itself, since the select clears
            dly_q <= {DW{1'b0}};
            if (por_ready && !bor_fire &&
                !(cause_q == CA_PIN && !external_rst_n_in)) begin
              state_q <= ST_DELAY;
            end
          end
          ST_DELAY: begin
            if (dly_q == REL_LAST) begin
              state_q <= ST_RUN;
            end else begin
              dly_q <= dly_q + {{(DW-1){1'b0}}, 1'b1};
            end
          end
          ST_WARM: begin
            if (!fast_rc_sel_in || wake_q == WAKE_LAST) begin
              state_q <= ST_RUN;
            end else begin
              wake_q <= wake_q + 5'd1;
            end
          end
          default: begin
            state_q <= ST_HOLD;
          end
        endcase
      end
    end
  end

  // Reset flags
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      to_q  <= 1'b0;
      pdf_q <= 1'b0;
    end else if (cold_src && state_q != ST_HOLD) begin
      if (wdt_cold) begin
        to_q <= 1'b1;
      end else if (pin_fire && sleep_in) begin
        to_q  <= 1'b0;
        pdf_q <= 1'b1;
      end
    end else if (state_q == ST_RUN && wdt_warm) begin
      to_q  <= 1'b1;
      pdf_q <= 1'b1;
    end
  end

  // Register bank; cold reset reloads, warm reset only sets pointer bit 7
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_sel_q  <= `RSTC_RST_PIN_SEL;
      wdt_ctrl_q <= `RSTC_RST_WDT_CTRL;
      wdt_per_q  <= `RSTC_RST_WDT_PER;
      intc_q     <= `RSTC_RST_INTERRUPT_CTRL0;
      tmr_ctrl_q <= `RSTC_RST_TIMER0_CTRL;
      pa_data_q  <= `RSTC_RST_PA_DATA;
      pa_dir_q   <= `RSTC_RST_PA_DIR;
      pa_pu_q    <= `RSTC_RST_PA_PU;
      pa_wu_q    <= `RSTC_RST_PA_WU;
      mp0_q      <= `RSTC_RST_MP;
      mp1_q      <= `RSTC_RST_MP;
    end else if (cold_load) begin
      pin_sel_q  <= `RSTC_RST_PIN_SEL;
      pa_data_q  <= `RSTC_RST_PA_DATA;
      pa_dir_q   <= `RSTC_RST_PA_DIR;
      pa_pu_q    <= `RSTC_RST_PA_PU;
      pa_wu_q    <= `RSTC_RST_PA_WU;
      wdt_ctrl_q <= `RSTC_RST_WDT_CTRL;
      wdt_per_q  <= `RSTC_RST_WDT_PER;
      intc_q     <= `RSTC_RST_INTERRUPT_CTRL0;
      tmr_ctrl_q <= `RSTC_RST_TIMER0_CTRL;
      mp0_q[`RSTC_MP_TOP_BIT] <= 1'b1;
      mp1_q[`RSTC_MP_TOP_BIT] <= 1'b1;
    end else if (state_q == ST_WARM) begin
      mp0_q[`RSTC_MP_TOP_BIT] <= 1'b1;
      mp1_q[`RSTC_MP_TOP_BIT] <= 1'b1;
    end else if (reg_wr_in && !in_reset) begin
      case (reg_addr_in)
        `RSTC_IDX_PIN_SEL:  pin_sel_q  <= reg_wdata_in[4:0];
        `RSTC_IDX_WDT_CTRL: wdt_ctrl_q <= reg_wdata_in;
        `RSTC_IDX_WDT_PER:  wdt_per_q  <= reg_wdata_in[2:0];
        `RSTC_IDX_INTERRUPT_CTRL0:    intc_q     <= reg_wdata_in;
        `RSTC_IDX_TIMER0_CTRL:    tmr_ctrl_q <= reg_wdata_in;
        `RSTC_IDX_PA_DATA:  pa_data_q  <= reg_wdata_in;
        `RSTC_IDX_PA_DIR:   pa_dir_q   <= reg_wdata_in;
        `RSTC_IDX_PA_PU:    pa_pu_q    <= reg_wdata_in;
        `RSTC_IDX_PA_WU:    pa_wu_q    <= reg_wdata_in;
        `RSTC_IDX_MP0:      mp0_q      <= reg_wdata_in;
        `RSTC_IDX_MP1:      mp1_q      <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // Registered read-back; unmapped indices read zero
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      case (reg_addr_in)
        `RSTC_IDX_PIN_SEL:  reg_rdata_out <= {3'h0, pin_sel_q};
        `RSTC_IDX_WDT_CTRL: reg_rdata_out <= wdt_ctrl_q;
        `RSTC_IDX_WDT_PER:  reg_rdata_out <= {5'h00, wdt_per_q};
        `RSTC_IDX_STATUS:   reg_rdata_out <= {2'h0, to_q, pdf_q, 4'h0};
        `RSTC_IDX_INTERRUPT_CTRL0:    reg_rdata_out <= intc_q;
        `RSTC_IDX_TIMER0_CTRL:    reg_rdata_out <= tmr_ctrl_q;
        `RSTC_IDX_PA_DATA:  reg_rdata_out <= pa_data_q;
        `RSTC_IDX_PA_DIR:   reg_rdata_out <= pa_dir_q;
        `RSTC_IDX_PA_PU:    reg_rdata_out <= pa_pu_q;
        `RSTC_IDX_PA_WU:    reg_rdata_out <= pa_wu_q;
        `RSTC_IDX_MP0:      reg_rdata_out <= mp0_q;
        `RSTC_IDX_MP1:      reg_rdata_out <= mp1_q;
        default:            reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Core sees reset for the whole sequence, warm wake included
  assign core_reset_out          = in_reset;
  assign pc_clear_out            = in_reset;
  assign sp_reset_out            = in_reset;
  assign warm_reset_out          = (state_q == ST_WARM);
  assign wdt_clear_out           = pulse_q || cold_load;
  assign timer_prescaler_clr_out = cold_load;
  assign pin_is_io_out           = (pin_sel_q == `RSTC_PIN_CODE_IO);
  assign pin_is_reset_out        = pin_mode_rst;
  assign wdt_enabled_out         = (wdt_ctrl_q[5:0] != `RSTC_WDT_CODE_OFF);
  assign watchdog_expiry_flag_out = to_q;
  assign powerdown_flag_out      = pdf_q;
  assign watchdog_control_out    = wdt_ctrl_q;
  assign watchdog_period_sel_out = wdt_per_q;
  assign interrupt_ctrl0_out     = intc_q;
  assign timer0_ctrl_out         = tmr_ctrl_q;
  assign port_a_data_out         = pa_data_q;
  assign port_a_direction_out    = pa_dir_q;
  assign port_a_pullup_out       = pa_pu_q;
  assign port_a_wake_enable_out  = pa_wu_q;
  assign mem_pointer0_out        = mp0_q;
  assign mem_pointer1_out        = mp1_q;
endmodule // rstc_ctrl
`default_nettype wire

// ===== sim/rstc_partner.sv
// Far side model: reset switch on the pin, supply monitor, slow RC.
// Assumes the bench calls press and dip from its main process.
`timescale 1ns/10ps
`default_nettype none
module rstc_partner (
  input  wire logic mclk_in,
  output var  logic external_rst_n_out,
  output var  logic brownout_low_out,
  output var  logic slow_rc_osc_out
);
  initial begin
    external_rst_n_out = 1'b1;
    brownout_low_out   = 1'b0;
    slow_rc_osc_out    = 1'b0;
    // Free running, edges fall on mclk falling edges
    forever #500 slow_rc_osc_out = ~slow_rc_osc_out;
  end
  // Pin pulled up again once the switch opens
  task automatic press(input int n);
    @(posedge mclk_in);
    external_rst_n_out <= 1'b0;
    repeat (n) @(posedge mclk_in);
    external_rst_n_out <= 1'b1;
    @(negedge mclk_in);
  endtask
  task automatic dip(input int n);
    @(posedge mclk_in);
    brownout_low_out <= 1'b1;
    repeat (n) @(posedge mclk_in);
    brownout_low_out <= 1'b0;
    @(negedge mclk_in);
  endtask
endmodule // rstc_partner
`default_nettype wire

// ===== sim/rstc_ctrl_chk.sv
// Port checker for rstc_ctrl, attached by bind.
// Assumes one clock mclk_in and asynchronous nrst_in.
`timescale 1ns/10ps
`default_nettype none
`include "rstc_map.vh"
module rstc_ctrl_chk (
  input wire logic       mclk_in,
  input wire logic       nrst_in,
  input wire logic       external_rst_n_in,
  input wire logic       brownout_low_in,
  input wire logic       fast_rc_sel_in,
  input wire logic       sleep_in,
  input wire logic       wdt_timeout_in,
  input wire logic       reg_wr_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       core_reset_out,
  input wire logic       warm_reset_out,
  input wire logic       pin_is_reset_out,
  input wire logic       watchdog_expiry_flag_out,
  input wire logic       powerdown_flag_out,
  input wire logic [7:0] timer0_ctrl_out,
  input wire logic [7:0] port_a_data_out,
  input wire logic [7:0] mem_pointer0_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  wire run = !core_reset_out;
  a_pin_enter: assert property (
    run && !external_rst_n_in && pin_is_reset_out |=> core_reset_out)
    else $error("pin reset not taken");
  a_bor_sleep: assert property (
    run && sleep_in && brownout_low_in && external_rst_n_in && !wdt_timeout_in |=> run)
    else $error("brownout acted in sleep");
  a_wdt_norm: assert property (
    run && wdt_timeout_in && !sleep_in |=> core_reset_out && !warm_reset_out
    ##1 watchdog_expiry_flag_out)
    else $error("watchdog normal reset wrong");
  a_wdt_sleep: assert property (
    run && wdt_timeout_in && sleep_in |=> warm_reset_out
    ##1 watchdog_expiry_flag_out && powerdown_flag_out)
    else $error("watchdog sleep reset wrong");
  a_warm_len: assert property (
    $rose(warm_reset_out) && $past(sleep_in) && fast_rc_sel_in |-> ##15 warm_reset_out
    ##1 !warm_reset_out)
    else $error("wake delay length wrong");
  a_warm_slow: assert property (
    $rose(warm_reset_out) && !fast_rc_sel_in |=> !warm_reset_out)
    else $error("slow clock wake length wrong");
  a_warm_keep: assert property (
    warm_reset_out |-> $stable(port_a_data_out) && $stable(timer0_ctrl_out))
    else $error("warm reset changed registers");
  a_cold_load: assert property (
    (core_reset_out && !warm_reset_out)[*2] |-> timer0_ctrl_out == `RSTC_RST_TIMER0_CTRL
    && port_a_data_out == `RSTC_RST_PA_DATA)
    else $error("cold reset values missing");
  a_ptr_bit7: assert property (
    core_reset_out[*2] |-> mem_pointer0_out[7])
    else $error("pointer top bit not set");
  a_code_fault: assert property (
    run && reg_wr_in && reg_addr_in == `RSTC_IDX_PIN_SEL && reg_wdata_in[4:0] != 5'h00
    && reg_wdata_in[4:0] != 5'h15 |=> (!core_reset_out)[*8] ##[1:62] core_reset_out)
    else $error("code fault reset timing wrong");
endmodule // rstc_ctrl_chk
bind rstc_ctrl rstc_ctrl_chk u_chk (.*);
`default_nettype wire

// ===== sim/rstc_ctrl_test.sv
// Self-checking bench for rstc_ctrl: sources, flags, reset values.
// Assumes rstc_partner drives the pin, supply and slow RC lines.
`timescale 1ns/10ps
`default_nettype none
`include "rstc_map.vh"
module rstc_ctrl_test;
  logic       mclk_in, nrst_in, fast_rc_sel_in, sleep_in, wdt_timeout_in, reg_wr_in;
  logic [3:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  wire        external_rst_n_in, brownout_low_in, slow_rc_osc_in, core_reset_out, pc_clear_out;
  wire        sp_reset_out, warm_reset_out, wdt_clear_out, timer_prescaler_clr_out, pin_is_io_out;
  wire        pin_is_reset_out, wdt_enabled_out, watchdog_expiry_flag_out, powerdown_flag_out;
  wire [2:0]  watchdog_period_sel_out;
  wire [7:0]  reg_rdata_out, watchdog_control_out, interrupt_ctrl0_out, timer0_ctrl_out;
  wire [7:0]  port_a_data_out, port_a_direction_out, port_a_pullup_out, port_a_wake_enable_out;
  wire [7:0]  mem_pointer0_out, mem_pointer1_out;
  int         error_cnt, checked, cyc;
  rstc_partner p (.mclk_in(mclk_in), .external_rst_n_out(external_rst_n_in),
    .brownout_low_out(brownout_low_in), .slow_rc_osc_out(slow_rc_osc_in));
  // Short release delay keeps the run brief
  rstc_ctrl #(.RELEASE_CYC(20)) dut (.*);
  task automatic report_and_stop();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    @(negedge mclk_in);
  endtask
  // No core reset may show for n cycles
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge mclk_in);
      seen = seen | core_reset_out;
    end
    chk({7'h0, seen}, 8'h00);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge mclk_in);
    reg_addr_in <= a;
    @(posedge mclk_in);
    @(negedge mclk_in);
    chk(reg_rdata_out & m, exp);
  endtask
  // Bounded wait for the core reset to reach a level
  task automatic wait_lvl(input logic v, input int lim);
    int n;
    n = 0;
    while (core_reset_out !== v && n < lim) begin
      @(negedge mclk_in);
      n++;
    end
    chk({7'h0, core_reset_out}, {7'h0, v});
  endtask
  task automatic wdt_pulse();
    @(posedge mclk_in);
    wdt_timeout_in <= 1'b1;
    @(posedge mclk_in);
    wdt_timeout_in <= 1'b0;
    @(negedge mclk_in);
  endtask
  task automatic t_por();
    logic [7:0] e [12];
    e = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h08, 8'hff, 8'hff, 8'h00, 8'h00, 8'h80, 8'h80};
    wait_lvl(1'b0, 400);
    for (int i = 0; i < 12; i++) begin
      rd(i[3:0], i == 3 ? 8'h30 : (i > 9 ? 8'h80 : 8'hff), e[i]);
    end
    rd(4'hf, 8'hff, 8'h00);
    chk(port_a_direction_out & port_a_data_out, 8'hff);
    chk(port_a_pullup_out | port_a_wake_enable_out | interrupt_ctrl0_out, 8'h00);
    chk(watchdog_control_out | {5'h00, watchdog_period_sel_out}, 8'h07);
    chk(timer0_ctrl_out, 8'h08);
    chk(mem_pointer1_out & 8'h80, 8'h80);
    chk({pin_is_io_out, pin_is_reset_out, wdt_enabled_out, timer_prescaler_clr_out,
         wdt_clear_out, 3'h0}, 8'ha0);
  endtask
  task automatic t_pin();
    wr(`RSTC_IDX_PA_DATA, 8'h5a);
    wr(`RSTC_IDX_MP0, 8'h05);
    p.press(4);
    quiet(3);
    wr(`RSTC_IDX_PIN_SEL, 8'h15);
    p.press(4);
    repeat (18) @(negedge mclk_in);
    chk({7'h0, core_reset_out}, 8'h01);
    wait_lvl(1'b0, 400);
    rd(`RSTC_IDX_PA_DATA, 8'hff, 8'hff);
    rd(`RSTC_IDX_PIN_SEL, 8'hff, 8'h00);
    rd(`RSTC_IDX_MP0, 8'hff, 8'h85);
    rd(`RSTC_IDX_STATUS, 8'h30, 8'h00);
  endtask
  task automatic t_wdt();
    wr(`RSTC_IDX_WDT_CTRL, 8'h2d);
    chk({7'h0, wdt_enabled_out}, 8'h00);
    wr(`RSTC_IDX_WDT_CTRL, 8'h00);
    chk({7'h0, wdt_enabled_out}, 8'h01);
    wr(`RSTC_IDX_TIMER0_CTRL, 8'h11);
    wdt_pulse();
    chk({4'h0, timer_prescaler_clr_out, wdt_clear_out, warm_reset_out, core_reset_out},
        8'h0d);
    wait_lvl(1'b0, 400);
    rd(`RSTC_IDX_STATUS, 8'h30, 8'h20);
    rd(`RSTC_IDX_TIMER0_CTRL, 8'hff, 8'h08);
  endtask
  task automatic t_sleep();
    wr(`RSTC_IDX_PA_DATA, 8'h3c);
    wr(`RSTC_IDX_WDT_PER, 8'h02);
    wr(`RSTC_IDX_MP0, 8'h12);
    @(posedge mclk_in);
    sleep_in <= 1'b1;
    fast_rc_sel_in <= 1'b1;
    wdt_pulse();
    chk({3'h0, wdt_clear_out, sp_reset_out, pc_clear_out, warm_reset_out, core_reset_out},
        8'h1f);
    repeat (15) @(negedge mclk_in);
    chk({7'h0, warm_reset_out}, 8'h01);
    @(negedge mclk_in);
    chk({7'h0, warm_reset_out}, 8'h00);
    @(posedge mclk_in);
    sleep_in <= 1'b0;
    rd(`RSTC_IDX_PA_DATA, 8'hff, 8'h3c);
    rd(`RSTC_IDX_WDT_PER, 8'hff, 8'h02);
    rd(`RSTC_IDX_MP0, 8'hff, 8'h92);
    rd(`RSTC_IDX_STATUS, 8'h30, 8'h30);
    // Slow clock wake is a single cycle
    @(posedge mclk_in);
    sleep_in <= 1'b1;
    fast_rc_sel_in <= 1'b0;
    wdt_pulse();
    chk({7'h0, warm_reset_out}, 8'h01);
    @(negedge mclk_in);
    chk({7'h0, warm_reset_out}, 8'h00);
    @(posedge mclk_in);
    sleep_in <= 1'b0;
  endtask
  task automatic t_halt_bor();
    wr(`RSTC_IDX_PIN_SEL, 8'h15);
    @(posedge mclk_in);
    sleep_in <= 1'b1;
    p.press(4);
    @(posedge mclk_in);
    sleep_in <= 1'b0;
    wait_lvl(1'b0, 400);
    rd(`RSTC_IDX_STATUS, 8'h30, 8'h10);
    p.dip(10);
    quiet(3);
    p.dip(30);
    chk({7'h0, core_reset_out}, 8'h01);
    wait_lvl(1'b0, 400);
    rd(`RSTC_IDX_STATUS, 8'h30, 8'h10);
    @(posedge mclk_in);
    sleep_in <= 1'b1;
    p.dip(30);
    @(posedge mclk_in);
    sleep_in <= 1'b0;
    quiet(3);
  endtask
  task automatic t_fault();
    wr(`RSTC_IDX_PIN_SEL, 8'h01);
    quiet(30);
    chk({7'h0, core_reset_out}, 8'h00);
    wait_lvl(1'b1, 35);
    wait_lvl(1'b0, 400);
    wr(`RSTC_IDX_WDT_CTRL, 8'h07);
    wait_lvl(1'b1, 70);
    wait_lvl(1'b0, 400);
    rd(`RSTC_IDX_WDT_CTRL, 8'hff, 8'h00);
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    {nrst_in, fast_rc_sel_in, sleep_in, wdt_timeout_in, reg_wr_in} = 5'h00;
    // Address and data are first set by the read and write tasks
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_por();
    t_pin();
    t_wdt();
    t_sleep();
    t_halt_bor();
    t_fault();
    @(posedge mclk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    nrst_in <= 1'b1;
    wait_lvl(1'b0, 400);
    rd(`RSTC_IDX_STATUS, 8'h30, 8'h00);
    report_and_stop();
  end
endmodule // rstc_ctrl_test
`default_nettype wire
